// ### sfp_pin_interface.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Deselected device floats every output lane
// - No instruction before first select falling edge
// - Single-lane input bits captured on rising clock
// - Single-lane output bits change on falling clock
// - Dual/quad lanes: in rising, out falling
// - Quad needs quad enable; lanes two, three
// - Guard pin low plus lock refuses status writes
// - Pause floats output, ignores input and clock
// - Pause release resumes with state intact
// - Quad enable disables pause and guard functions
// - Dedicated reset pin always honoured
// - Floating dedicated reset counts as inactive
// - Lane three is pause or reset
// - Works in clock mode 0 and 3
// - Internal busy cycle survives deselection
// - Select low makes device selected, ready
// - Pause starts/ends with clock low
// - Pin-function bit: clear pause, set reset
// - Reset low one microsecond gives power-on state
module sfp_pin_interface (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic lane_zero_in,
  output logic lane_zero_out,
  output logic lane_zero_oe,
  input wire logic lane_one_in,
  output logic lane_one_out,
  output logic lane_one_oe,
  input wire logic lane_two_in,
  output logic lane_two_out,
  output logic lane_two_oe,
  input wire logic lane_three_in,
  output logic lane_three_out,
  output logic lane_three_oe,
  input wire logic dedicated_reset_n,
  input wire logic has_dedicated_reset,
  input wire logic quad_lane_enable,
  input wire logic pin_func_reset,
  input wire logic status_lock_bits,
  input wire logic [1:0] lane_mode,
  input wire logic drive_enable,
  input wire logic [sfp_pkg::UNIT_W-1:0] tx_unit,
  output logic tx_taken,
  output logic [sfp_pkg::UNIT_W-1:0] rx_unit,
  output logic rx_valid,
  output logic rx_first,
  input wire logic status_write_req,
  output logic status_write_ok,
  input wire logic internal_busy,
  output logic busy,
  output logic selected,
  output logic paused,
  output logic device_reset
);
  // *******************
  // Reset synchroniser
  // *******************
  logic rst_meta; // First stage
  logic rst_sync_n; // Released reset
  // Release the block reset through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // *****************
  // Pin synchronisers
  // *****************
  logic [6:0] pin_meta; // First stages, read only by second
  logic [6:0] pin_sync; // Second stages
  // Two flops for every pin from outside
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= 7'h7F;
      pin_sync <= 7'h7F;
    end else begin
      pin_meta <= {select_n, serial_clock, lane_zero_in, lane_one_in,
                   lane_two_in, lane_three_in, dedicated_reset_n};
      pin_sync <= pin_meta;
    end
  end
  logic cs_n_s; // Synced select
  logic sck_s; // Synced link clock
  logic l0_s; // Synced lane zero
  logic l1_s; // Synced lane one
  logic l2_s; // Synced lane two
  logic l3_s; // Synced lane three
  logic rst_pin_s; // Synced dedicated reset
  assign cs_n_s = pin_sync[6];
  assign sck_s = pin_sync[5];
  assign l0_s = pin_sync[4];
  assign l1_s = pin_sync[3];
  assign l2_s = pin_sync[2];
  assign l3_s = pin_sync[1];
  assign rst_pin_s = pin_sync[0];

  // ******************
  // Edge history
  // ******************
  logic cs_n_d; // Previous select
  logic sck_d; // Previous link clock
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cs_n_d <= 1'b1;
      sck_d <= 1'b1; // Matches synchroniser reset level
    end else begin
      cs_n_d <= cs_n_s;
      sck_d <= sck_s;
    end
  end
  logic cs_fall; // Select asserted
  logic cs_rise; // Select released
  logic sck_rise; // Link clock rising
  logic sck_fall; // Link clock falling
  assign cs_fall = cs_n_d && !cs_n_s;
  assign cs_rise = !cs_n_d && cs_n_s;
  assign sck_rise = !sck_d && sck_s;
  assign sck_fall = sck_d && !sck_s;

  // ************************
  // Shared pin functions
  // ************************
  logic pause_pin_live; // Lane three is a pause input
  logic reset_pin_live; // Lane three is a reset input
  logic guard_live; // Lane two is a write guard
  assign pause_pin_live = !quad_lane_enable && !pin_func_reset;
  assign reset_pin_live = !quad_lane_enable && pin_func_reset;
  assign guard_live = !quad_lane_enable;
  // Floating reset pin synchronises to high, so it is inactive
  logic hw_reset_low; // Any hardware reset pin asserted
  assign hw_reset_low = (has_dedicated_reset && !rst_pin_s) ||
                        (reset_pin_live && !l3_s);

  // Count reset-low time
  logic [sfp_pkg::RESET_CNT_W-1:0] rst_cnt;
  logic [sfp_pkg::RESET_CNT_W-1:0] next_rst_cnt;
  logic dev_rst; // Held in power-on state
  logic next_dev_rst;
  always_comb begin
    next_rst_cnt = '0;
    next_dev_rst = dev_rst;
    if (hw_reset_low) begin
      if (rst_cnt != sfp_pkg::RESET_CNT_W'(sfp_pkg::RESET_LOW_CYCLES))
        next_rst_cnt = rst_cnt + 1'b1;
      else
        next_rst_cnt = rst_cnt;
      if (rst_cnt >= sfp_pkg::RESET_CNT_W'(sfp_pkg::RESET_LOW_CYCLES - 1))
        next_dev_rst = 1'b1;
    end else begin
      next_dev_rst = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rst_cnt <= '0;
      dev_rst <= 1'b0;
    end else begin
      rst_cnt <= next_rst_cnt;
      dev_rst <= next_dev_rst;
    end
  end

  // ************************
  // Transfer state machine
  // ************************
  sfp_pkg::sfp_state_t state;
  sfp_pkg::sfp_state_t next_state;
  logic pause_req; // Pause pin held low
  logic [2:0] bit_cnt; // Bits held in current unit
  logic [2:0] next_bit_cnt;
  logic [7:0] shift_in; // Incoming unit
  logic [7:0] next_shift_in;
  logic [7:0] shift_out, next_shift_out; // Outgoing unit
  logic [7:0] rx_reg, next_rx_reg; // Last finished unit
  logic rx_v, next_rx_v; // Unit finished pulse
  logic first_unit; // Next unit is the instruction
  logic next_first_unit;
  logic rx_first_reg, next_rx_first; // Finished unit was first
  logic take, next_take; // Outgoing unit loaded pulse
  logic [3:0] out_bits, next_out_bits; // Lane output values
  logic [2:0] step; // Bits per clock minus one
  logic quad_ok; // Quad lanes allowed
  assign pause_req = pause_pin_live && !l3_s;
  assign quad_ok = quad_lane_enable;
  always_comb begin
    unique case (lane_mode)
      2'(sfp_pkg::SFP_LANE_DUAL): step = 3'd1;
      2'(sfp_pkg::SFP_LANE_QUAD): step = quad_ok ? 3'd3 : 3'd0;
      default: step = 3'd0;
    endcase
  end
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_rx_reg = rx_reg;
    next_rx_v = 1'b0;
    next_first_unit = first_unit;
    next_rx_first = rx_first_reg;
    next_take = 1'b0;
    next_out_bits = out_bits;
    unique case (state)
      sfp_pkg::SFP_ST_WAIT_FIRST: begin
        if (cs_fall) begin
          next_state = sfp_pkg::SFP_ST_ACTIVE;
        end
      end
      sfp_pkg::SFP_ST_IDLE: begin
        if (cs_fall) begin
          next_state = sfp_pkg::SFP_ST_ACTIVE;
        end
      end
      sfp_pkg::SFP_ST_ACTIVE: begin
        // Pause takes effect only while the clock is low
        if (pause_req && !sck_s && !sck_rise) begin
          next_state = sfp_pkg::SFP_ST_PAUSED;
        end else if (sck_rise) begin
          unique case (step)
            3'd1: next_shift_in = {shift_in[5:0], l1_s, l0_s};
            3'd3: next_shift_in = {shift_in[3:0], l3_s, l2_s, l1_s, l0_s};
            default: next_shift_in = {shift_in[6:0], l0_s};
          endcase
          next_bit_cnt = bit_cnt + step + 3'd1;
          if (bit_cnt + step == 3'd7) begin
            next_rx_reg = next_shift_in;
            next_rx_v = 1'b1;
            next_rx_first = first_unit;
            next_first_unit = 1'b0;
          end
        end else if (sck_fall) begin
          if (bit_cnt == 3'd0 || (bit_cnt == 3'd1 && first_unit)) begin
            next_shift_out = tx_unit;
            next_take = drive_enable;
          end
          unique case (step)
            3'd1: next_out_bits = {2'b00, next_shift_out[7:6]};
            3'd3: next_out_bits = next_shift_out[7:4];
            default: next_out_bits = {2'b00, next_shift_out[7], 1'b0};
          endcase
          next_shift_out = next_shift_out << (step + 3'd1);
        end
      end
      sfp_pkg::SFP_ST_PAUSED: begin
        // Resume with all shift state intact
        if (!pause_req && !sck_s) begin
          next_state = sfp_pkg::SFP_ST_ACTIVE;
        end
      end
    endcase
    // Deselection drops any partial unit
    if (cs_rise && state != sfp_pkg::SFP_ST_WAIT_FIRST) begin
      next_state = sfp_pkg::SFP_ST_IDLE;
      next_bit_cnt = 3'd0;
      next_shift_in = 8'h00;
      next_first_unit = 1'b1;
      next_out_bits = 4'h0;
    end
    if (dev_rst) begin
      next_state = sfp_pkg::SFP_ST_WAIT_FIRST;
      next_bit_cnt = 3'd0;
      next_shift_in = 8'h00;
      next_first_unit = 1'b1;
      next_rx_v = 1'b0;
      next_take = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= sfp_pkg::SFP_ST_WAIT_FIRST;
      bit_cnt <= 3'd0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      rx_reg <= 8'h00;
      rx_v <= 1'b0;
      first_unit <= 1'b1;
      rx_first_reg <= 1'b0;
      take <= 1'b0;
      out_bits <= 4'h0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      rx_reg <= next_rx_reg;
      rx_v <= next_rx_v;
      first_unit <= next_first_unit;
      rx_first_reg <= next_rx_first;
      take <= next_take;
      out_bits <= next_out_bits;
    end
  end

  // *****************
  // Output lanes
  // *****************
  logic lanes_on; // Device may drive
  assign lanes_on = (state == sfp_pkg::SFP_ST_ACTIVE) && !cs_n_s &&
                    drive_enable && !dev_rst;
  assign lane_zero_out = out_bits[0];
  assign lane_one_out = out_bits[1];
  assign lane_two_out = out_bits[2];
  assign lane_three_out = out_bits[3];
  assign lane_zero_oe = lanes_on && step != 3'd0;
  assign lane_one_oe = lanes_on;
  assign lane_two_oe = lanes_on && step == 3'd3;
  assign lane_three_oe = lanes_on && step == 3'd3;
  assign tx_taken = take;
  assign rx_unit = rx_reg;
  assign rx_valid = rx_v;
  assign rx_first = rx_first_reg;
  // Guard low with lock set refuses status writes
  assign status_write_ok = status_write_req && !dev_rst &&
                           !(guard_live && !l2_s && status_lock_bits);
  // Busy cycle runs on regardless of select
  assign busy = internal_busy;
  assign selected = (state == sfp_pkg::SFP_ST_ACTIVE) ||
                    (state == sfp_pkg::SFP_ST_PAUSED);
  assign paused = state == sfp_pkg::SFP_ST_PAUSED;
  assign device_reset = dev_rst;
endmodule
`default_nettype wire

// ### sfp_pkg.sv
`default_nettype none
package sfp_pkg;
  // ***********************
  // Pin-interface constants
  // ***********************
  // Cycle period of the block clock in ps
  localparam int unsigned CLOCK_PERIOD_PS = 4000;
  // Least low time of the dedicated reset pin in ns
  localparam int unsigned RESET_LOW_NS = 1000;
  // Least low time of the reset pin in block clock cycles
  localparam int unsigned RESET_LOW_CYCLES =
    (RESET_LOW_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  // Width of the reset-low counter
  localparam int unsigned RESET_CNT_W = 9;
  // Factory default of the shared pin-function select bit
  localparam logic PIN_FUNC_RESET_VALUE = 1'b0;
  // Width of one shifted unit (instruction, address or data byte)
  localparam int unsigned UNIT_W = 8;
  // Lane width encodings
  typedef enum logic [1:0] {
    SFP_LANE_SINGLE,
    SFP_LANE_DUAL,
    SFP_LANE_QUAD
  } sfp_lane_t;
  // Top-level transfer state
  typedef enum logic [1:0] {
    SFP_ST_WAIT_FIRST,
    SFP_ST_IDLE,
    SFP_ST_ACTIVE,
    SFP_ST_PAUSED
  } sfp_state_t;
endpackage
`default_nettype wire

// ### sfp_pin_interface_props.sv
`timescale 1ns/1ps
`default_nettype none
// *********************
// Pin interface checker
// *********************
module sfp_pin_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic lane_two_in,
  input wire logic lane_one_oe,
  input wire logic quad_lane_enable,
  input wire logic status_lock_bits,
  input wire logic status_write_ok,
  input wire logic selected,
  input wire logic paused,
  input wire logic rx_valid,
  input wire logic device_reset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Select pin settled past the synchroniser
  sequence s_idle; select_n [*5]; endsequence
  sequence s_held; (!select_n && !device_reset) [*6]; endsequence
  a_idle_float: assert property (
    s_idle |-> !lane_one_oe) else $error("lane driven while idle");
  a_select_ready: assert property (
    s_held |-> selected) else $error("select not taken");
  a_idle_drops: assert property (
    s_idle |-> !selected) else $error("select kept");
  a_unit_selected: assert property (
    rx_valid |-> selected) else $error("unit while unselected");
  a_reset_quiet: assert property (
    device_reset [*2] |-> !selected && !rx_valid) else $error("busy in reset");
  a_pause_float: assert property (
    paused [*2] |-> !lane_one_oe) else $error("lane driven in pause");
  a_no_pause: assert property (
    quad_lane_enable [*4] |-> !paused) else $error("pause with quad");
  a_guard_refuse: assert property (
    (status_lock_bits && !lane_two_in && !quad_lane_enable) [*4]
    |-> !status_write_ok) else $error("guarded write allowed");
endmodule
bind sfp_pin_interface sfp_pin_props u_sfp_pin_props (
  .clock(clock), .rst_n(rst_n), .select_n(select_n),
  .lane_two_in(lane_two_in), .lane_one_oe(lane_one_oe),
  .quad_lane_enable(quad_lane_enable), .status_lock_bits(status_lock_bits),
  .status_write_ok(status_write_ok), .selected(selected), .paused(paused),
  .rx_valid(rx_valid), .device_reset(device_reset)
);
`default_nettype wire

// ### sfp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// **************
// Host bus model
// **************
module sfp_host_model (
  input wire logic clock,
  output logic select_n,
  output logic serial_clock,
  output logic [3:0] lanes,
  input wire logic [3:0] bus
);
  logic idle_hi; // Clock level between frames
  // Deselected, lanes high
  initial begin
    select_n = 1'b1;
    serial_clock = 1'b0;
    lanes = 4'hF;
    idle_hi = 1'b0;
  end
  // Wait block clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Park clock at the mode's idle level, then select
  task automatic open_frame(input logic mode3);
    idle_hi = mode3;
    serial_clock <= mode3;
    lanes <= 4'hF;
    tick(4);
    select_n <= 1'b0;
    tick(6);
  endtask
  // Data set on the fall, read on the rise, w lanes a step
  task automatic shift(input int w, input int nb, input logic [7:0] tx,
    output logic [7:0] rx);
    logic [3:0] v;
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    rx = 8'h00;
    for (int i = 0; i < nb; i += w) begin
      v = 4'(tx >> (8 - w));
      tx = tx << w;
      serial_clock <= 1'b0;
      lanes <= (lanes & ~m) | (v & m);
      tick(6);
      rx = (rx << w) | 8'((w == 1) ? 4'(bus[1]) : bus & m);
      serial_clock <= 1'b1;
      tick(6);
    end
  endtask
  // Park clock, then deselect
  task automatic close_frame();
    serial_clock <= idle_hi;
    tick(6);
    select_n <= 1'b1;
    tick(8);
  endtask
  // Hold lanes at a level
  task automatic set_lanes(input logic [3:0] v);
    lanes <= v;
    tick(6);
  endtask
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
// *******************
// Pin interface bench
// *******************
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic dedicated_reset_n;
  logic has_dedicated_reset;
  logic quad_lane_enable;
  logic pin_func_reset;
  logic status_lock_bits;
  logic [1:0] lane_mode;
  logic drive_enable;
  logic [7:0] tx_unit;
  logic status_write_req;
  logic internal_busy;
  logic tx_taken;
  int n_taken = 0;
  logic select_n;
  logic serial_clock;
  logic [3:0] lanes;
  logic [3:0] bus;
  logic [3:0] dout;
  logic [3:0] doe;
  logic [7:0] rx_unit;
  logic [7:0] got;
  logic [7:0] r;
  logic rx_valid;
  logic rx_first;
  logic got_first;
  logic status_write_ok;
  logic busy;
  logic selected;
  logic paused;
  logic device_reset;
  int err_total = 0;
  int n_tests = 0;
  // Block clock
  always #2 clock = ~clock;
  // Wire level: device wins where it drives
  assign bus = (doe & dout) | (~doe & lanes);
  // Keep each finished unit
  always @(posedge clock) begin
    if (rx_valid === 1'b1) begin
      got <= rx_unit;
      got_first <= rx_first;
    end
  end
  // Count loaded outgoing units
  always @(posedge clock) begin
    if (tx_taken === 1'b1) begin
      n_taken <= n_taken + 1;
    end
  end
  sfp_pin_interface u_sfp_pin_interface (
    .clock(clock), .rst_n(rst_n), .select_n(select_n),
    .serial_clock(serial_clock), .lane_zero_in(bus[0]),
    .lane_zero_out(dout[0]), .lane_zero_oe(doe[0]), .lane_one_in(bus[1]),
    .lane_one_out(dout[1]), .lane_one_oe(doe[1]), .lane_two_in(bus[2]),
    .lane_two_out(dout[2]), .lane_two_oe(doe[2]), .lane_three_in(bus[3]),
    .lane_three_out(dout[3]), .lane_three_oe(doe[3]),
    .dedicated_reset_n(dedicated_reset_n),
    .has_dedicated_reset(has_dedicated_reset),
    .quad_lane_enable(quad_lane_enable), .pin_func_reset(pin_func_reset),
    .status_lock_bits(status_lock_bits), .lane_mode(lane_mode),
    .drive_enable(drive_enable), .tx_unit(tx_unit), .tx_taken(tx_taken),
    .rx_unit(rx_unit), .rx_valid(rx_valid), .rx_first(rx_first),
    .status_write_req(status_write_req), .status_write_ok(status_write_ok),
    .internal_busy(internal_busy), .busy(busy), .selected(selected),
    .paused(paused), .device_reset(device_reset)
  );
  sfp_host_model u_host (
    .clock(clock), .select_n(select_n), .serial_clock(serial_clock),
    .lanes(lanes), .bus(bus)
  );
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    dedicated_reset_n <= 1'b1; // Tied high when unused
    has_dedicated_reset <= 1'b0;
    quad_lane_enable <= 1'b0;
    pin_func_reset <= sfp_pkg::PIN_FUNC_RESET_VALUE;
    status_lock_bits <= 1'b0;
    lane_mode <= 2'h0;
    drive_enable <= 1'b0;
    tx_unit <= 8'h00;
    status_write_req <= 1'b0;
    internal_busy <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    u_host.tick(6);
    check("oe idle", 8'(doe), 8'h00);
    // Lane widths in both clock modes: write unit, then read unit
    for (int m = 0; m < 6; m++) begin
      quad_lane_enable <= (m % 3 == 2);
      lane_mode <= 2'(m % 3);
      u_host.open_frame(m >= 3);
      u_host.shift(1 << (m % 3), 8, 8'h90 + 8'(m), r);
      check("unit", got, 8'h90 + 8'(m));
      check("first", 8'(got_first), 8'h01);
      drive_enable <= 1'b1;
      tx_unit <= 8'hA5 - 8'(m);
      u_host.shift(1 << (m % 3), 8, 8'h33, r);
      check("read", r, 8'hA5 - 8'(m));
      drive_enable <= 1'b0;
      u_host.close_frame();
    end
    quad_lane_enable <= 1'b0;
    lane_mode <= 2'h0;
    check("taken", 8'(n_taken), 8'h06);
    $display("lane test done");
    // Partial unit dropped, then a paused unit resumed
    u_host.open_frame(1'b0);
    u_host.shift(1, 3, 8'hFF, r);
    u_host.close_frame();
    u_host.open_frame(1'b0);
    u_host.shift(1, 4, 8'hC0, r);
    drive_enable <= 1'b1;
    u_host.set_lanes(4'h7);
    check("not yet", 8'(paused), 8'h00);
    check("drive", 8'(doe[1]), 8'h01);
    u_host.shift(1, 4, 8'hFF, r);
    check("paused", 8'(paused), 8'h01);
    check("float", 8'(doe[1]), 8'h00);
    drive_enable <= 1'b0;
    u_host.set_lanes(4'hF);
    u_host.shift(1, 4, 8'h30, r);
    check("resumed", got, 8'hC3);
    check("restart", 8'(got_first), 8'h01);
    u_host.close_frame();
    $display("pause test done");
    // Guard pin against lock bit and quad lanes
    status_write_req <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      status_lock_bits <= (g != 3);
      quad_lane_enable <= (g == 2);
      u_host.set_lanes((g == 1) ? 4'hF : 4'hB);
      check("write ok", 8'(status_write_ok), 8'((g != 0)));
    end
    quad_lane_enable <= 1'b0;
    status_write_req <= 1'b0;
    u_host.tick(2);
    check("no write", 8'(status_write_ok), 8'h00);
    $display("guard test done");
    // Internal cycle outlives deselection
    internal_busy <= 1'b1;
    u_host.open_frame(1'b0);
    u_host.close_frame();
    check("busy", 8'(busy), 8'h01);
    internal_busy <= 1'b0;
    u_host.tick(2);
    check("busy done", 8'(busy), 8'h00);
    $display("busy test done");
    // Dedicated reset pin, then lane three as reset
    for (int s = 0; s < 2; s++) begin
      has_dedicated_reset <= (s == 0);
      quad_lane_enable <= (s == 0);
      pin_func_reset <= (s == 1);
      dedicated_reset_n <= (s != 0);
      u_host.set_lanes((s == 1) ? 4'h7 : 4'hF);
      for (int k = 0; k < 400 && device_reset !== 1'b1; k++) begin
        u_host.tick(1);
      end
      check("reset in", 8'(device_reset), 8'h01);
      dedicated_reset_n <= 1'b1;
      u_host.set_lanes(4'hF);
      u_host.tick(4);
      check("reset out", 8'(device_reset), 8'h00);
    end
    $display("reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
